// [logic/rcu_ctrl.sv]
// RTC timekeeping counters, alarms and control register with its register port.
// Assumes lf_tick_in is a one-cycle pulse per 32768 Hz edge, already synchronous.
// rst_n_in is power-on reset; the other reset sources arrive as synchronous levels.
//
// Implementation choice: the plain strobed port.
`include "rcu_params.svh"

////////////////////////////////////////////////////////////////////////////////
// Operation
// RQ1 - Unlock set: trim and run enable writable
// RQ2 - Unlock clear: trim and run enable frozen
// RQ3 - Unlock cleared by every reset source
// RQ4 - Direct read returns live counters
// RQ5 - Software repeats direct reads until equal
// RQ6 - Otherwise synchronised counters, read during ready
// RQ7 - Select field picks 1Hz, 512Hz, 4kHz
// RQ8 - Enable bit drives square wave pin
// RQ9 - Sub-second alarm sets its pending flag
// RQ10 - Sub-second flag wakes the device
// RQ11 - Time-of-day alarm sets its pending flag
// RQ12 - Square wave and flags reset by power-on only
// RQ13 - Alarm matches low 20 seconds bits, interrupts
// RQ14 - Ready held 120us after sync, clearable
// RQ15 - Busy during transfer blocks control writes; the code still lets the ready clear through
// RQ16 - Write zero clears flag, set wins
// RQ17 - Reserved bits read zero, ignore writes
module rcu_ctrl
   import rcu_pkg::*;
#(
   parameter int RDY_CYC = `RCU_RDY_TIME_NS * `RCU_CLK_MHZ / 1000,
   parameter int BUSY_CYC = `RCU_BUSY_CYC
) (
   // Clock and power-on reset
   input wire logic sys_clk_in,
   input wire logic rst_n_in,
   // Warm reset sources
   input wire logic sys_reset_in,
   input wire logic soft_reset_in,
   input wire logic peripheral_reset_request_in,
   input wire logic alt_peripheral_reset_request_in,
   // Low-speed timebase
   input wire logic lf_tick_in,
   // Register port
   input wire logic [7:0] addr_in,
   input wire logic [31:0] wdata_in,
   input wire logic wr_in,
   input wire logic rd_in,
   output logic [31:0] rdata_out,
   // Pins and events
   output logic sqw_out,
   output logic wakeup_out,
   output logic irq_out
);

   ////////////////////////////////////////////////////////////////////////////
   // Declarations

   // Counting state
   logic [2:0] presc_r; // 32k to 4k prescaler
   logic [`RCU_SSEC_W-1:0] ssec_r; // Sub-second count
   logic [31:0] sec_r; // Seconds count
   logic [31:0] sseca_r; // Sub-second alarm reload
   logic [31:0] sacnt_r; // Sub-second alarm counter
   logic [`RCU_TODA_W-1:0] toda_r; // Time-of-day alarm value
   logic [`RCU_TRIM_W-1:0] trim_r; // Oscillator trim
   // Synchronised copies
   logic [`RCU_SSEC_W-1:0] ssec_sh_r;
   logic [31:0] sec_sh_r;
   logic sync_r; // Pulse after each sub-second step
   // Control fields
   logic wr_en_r; // Write unlock
   logic rd_en_r; // Direct read
   logic [1:0] sqw_sel_r; // Square-wave select
   logic sqw_en_r; // Square-wave enable
   logic ssal_r; // Sub-second alarm flag
   logic todal_r; // Time-of-day alarm flag
   logic rdy_r; // Ready flag
   logic en_r; // Counter run enable
   logic ssal_nxt;
   logic todal_nxt;
   logic rdy_nxt;
   // Busy and ready timers
   logic [15:0] busy_cnt_r;
   logic [31:0] rdy_cnt_r;
   logic busy;
   // Interrupt status and mask
   logic [`RCU_IRQ_W-1:0] istat_r;
   logic [`RCU_IRQ_W-1:0] istat_nxt;
   logic [`RCU_IRQ_W-1:0] imask_r;
   logic [`RCU_IRQ_W-1:0] ev;
   logic irq_r;
   logic wake_r;
   logic [31:0] rdata_r;

   ////////////////////////////////////////////////////////////////////////////
   // Decode

   // Any non-power-on reset source
   wire warm_rst = sys_reset_in | soft_reset_in |
                   peripheral_reset_request_in | alt_peripheral_reset_request_in;
   // Address selects
   wire sel_sec = addr_in == `RCU_OFF_SEC;
   wire sel_ssec = addr_in == `RCU_OFF_SSEC;
   wire sel_toda = addr_in == `RCU_OFF_TODA;
   wire sel_sseca = addr_in == `RCU_OFF_SSECA;
   wire sel_ctrl = addr_in == `RCU_OFF_CTRL;
   wire sel_trim = addr_in == `RCU_OFF_TRIM;
   wire sel_istat = addr_in == `RCU_OFF_ISTAT;
   wire sel_imask = addr_in == `RCU_OFF_IMASK;
   // Write strobes
   wire wr_sec = wr_in & sel_sec;
   wire wr_ssec = wr_in & sel_ssec;
   wire wr_toda = wr_in & sel_toda;
   wire wr_sseca = wr_in & sel_sseca;
   wire wr_ctrl = wr_in & sel_ctrl;
   wire wr_imask = wr_in & sel_imask;
   // Trim writes pass only while unlocked
   wire wr_trim = wr_in & sel_trim & wr_en_r; //RQ1 RQ2
   // Control fields frozen while a transfer runs; the ready clear uses wr_ctrl and still passes
   wire ctrl_wr = wr_ctrl & ~busy; //RQ15
   // Run enable needs the unlock as well
   wire en_wr = ctrl_wr & wr_en_r; //RQ1 RQ2
   // Status read clears the sticky bits
   wire istat_rd = rd_in & sel_istat;
   // Transfers that raise busy
   wire xfer_start = wr_sec | wr_ssec | wr_trim; //RQ15

   ////////////////////////////////////////////////////////////////////////////
   // Timebase

   // Sub-second step every eighth low-speed tick
   wire ssec_tick = lf_tick_in & en_r & (presc_r == 3'h7);
   // Seconds step on sub-second wrap
   wire sec_tick = ssec_tick & (ssec_r == {`RCU_SSEC_W{1'b1}});
   wire [31:0] sec_inc = sec_r + 32'h1;
   // Alarm counter wraps from all ones
   wire sa_wrap = ssec_tick & (sacnt_r == 32'hffffffff);
   // Time-of-day compare on the value the seconds count is taking
   wire tod_hit = sec_tick & (sec_inc[`RCU_TODA_W-1:0] == toda_r); //RQ13

   // Prescaler runs only while counting is enabled
   always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         presc_r <= 3'h0;
      end else if (warm_rst || wr_ssec) begin
         presc_r <= 3'h0;
      end else if (lf_tick_in && en_r) begin
         presc_r <= presc_r + 3'h1;
      end
   end

   // Sub-second counter; a write restarts it
   always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         ssec_r <= '0;
      end else if (warm_rst) begin
         ssec_r <= '0;
      end else if (wr_ssec) begin
         ssec_r <= wdata_in[`RCU_SSEC_W-1:0];
      end else if (ssec_tick) begin
         ssec_r <= ssec_r + `RCU_SSEC_W'(1);
      end
   end

   // Seconds counter
   always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         sec_r <= 32'h0;
      end else if (warm_rst) begin
         sec_r <= 32'h0;
      end else if (wr_sec) begin
         sec_r <= wdata_in;
      end else if (sec_tick) begin
         sec_r <= sec_inc;
      end
   end

   // Alarm values and trim
   always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         toda_r <= '0;
         sseca_r <= 32'h0;
         trim_r <= `RCU_TRIM_RST;
      end else if (warm_rst) begin
         toda_r <= '0;
         sseca_r <= 32'h0;
         trim_r <= `RCU_TRIM_RST;
      end else begin
         if (wr_toda) begin
            toda_r <= wdata_in[`RCU_TODA_W-1:0];
         end
         if (wr_sseca) begin
            sseca_r <= wdata_in;
         end
         // Ignored while locked
         if (wr_trim) begin
            trim_r <= wdata_in[`RCU_TRIM_W-1:0]; //RQ1
         end
      end
   end

   // Sub-second alarm counter reloads on write and on wrap
   always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         sacnt_r <= 32'h0;
      end else if (warm_rst) begin
         sacnt_r <= 32'h0;
      end else if (wr_sseca) begin
         sacnt_r <= wdata_in;
      end else if (sa_wrap) begin
         sacnt_r <= sseca_r;
      end else if (ssec_tick) begin
         sacnt_r <= sacnt_r + 32'h1;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Synchronised view and ready window

   // Copies refresh one cycle after each step, once live values settled
   always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         sync_r <= 1'b0;
         ssec_sh_r <= '0;
         sec_sh_r <= 32'h0;
      end else begin
         sync_r <= ssec_tick & ~warm_rst;
         if (sync_r) begin
            ssec_sh_r <= ssec_r; //RQ6
            sec_sh_r <= sec_r;
         end
      end
   end

   // Ready: set on sync, ends after the window or on a software zero
   assign rdy_nxt = sync_r ? 1'b1 : //RQ14
                    (rdy_cnt_r == 32'h1) ? 1'b0 :
                    (wr_ctrl && !wdata_in[`RCU_B_RDY]) ? 1'b0 : rdy_r;

   // Window length counter; a new sync restarts the window
   always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         rdy_r <= 1'b0;
         rdy_cnt_r <= 32'h0;
      end else if (warm_rst) begin
         rdy_r <= 1'b0;
         rdy_cnt_r <= 32'h0;
      end else begin
         rdy_r <= rdy_nxt;
         if (sync_r) begin
            rdy_cnt_r <= 32'(RDY_CYC); //RQ14
         end else if (rdy_cnt_r != 32'h0) begin
            rdy_cnt_r <= rdy_cnt_r - 32'h1;
         end
      end
   end

   // Busy counts out a fixed transfer time
   assign busy = busy_cnt_r != 16'h0;
   always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         busy_cnt_r <= 16'h0;
      end else if (warm_rst) begin
         busy_cnt_r <= 16'h0;
      end else if (xfer_start) begin
         busy_cnt_r <= 16'(BUSY_CYC); //RQ15
      end else if (busy) begin
         busy_cnt_r <= busy_cnt_r - 16'h1;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Control fields

   // Hardware set beats a same-cycle software clear
   assign ssal_nxt = sa_wrap | //RQ9
                     (ssal_r & ~(ctrl_wr & ~wdata_in[`RCU_B_SSAL])); //RQ16
   assign todal_nxt = tod_hit | //RQ11
                      (todal_r & ~(ctrl_wr & ~wdata_in[`RCU_B_TODAL])); //RQ16

   // Warm-reset fields: unlock, direct read, run enable
   always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         wr_en_r <= 1'b0;
         rd_en_r <= 1'b0;
         en_r <= 1'b0;
      end else if (warm_rst) begin
         wr_en_r <= 1'b0; //RQ3
         rd_en_r <= 1'b0;
         en_r <= 1'b0;
      end else begin
         if (ctrl_wr) begin
            wr_en_r <= wdata_in[`RCU_B_WREN];
            rd_en_r <= wdata_in[`RCU_B_RDEN];
         end
         if (en_wr) begin
            en_r <= wdata_in[`RCU_B_EN]; //RQ1
         end
      end
   end

   // Power-on-only fields ride through warm resets
   always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         sqw_sel_r <= 2'h0; //RQ12
         sqw_en_r <= 1'b0;
         ssal_r <= 1'b0;
         todal_r <= 1'b0;
      end else begin
         ssal_r <= ssal_nxt;
         todal_r <= todal_nxt;
         if (ctrl_wr) begin
            sqw_sel_r <= wdata_in[`RCU_B_SELHI:`RCU_B_SELLO];
            sqw_en_r <= wdata_in[`RCU_B_SQWEN];
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Interrupts and wake-up

   // Events: ready rise, sub-second alarm, time-of-day alarm
   assign ev = {sync_r, sa_wrap, tod_hit}; //RQ13
   // A new event beats the read that clears it
   assign istat_nxt = ev | (istat_r & ~{`RCU_IRQ_W{istat_rd}});

   // Sticky status, mask and the level output
   always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         istat_r <= '0;
         imask_r <= `RCU_IMASK_RST;
         irq_r <= 1'b0;
      end else if (warm_rst) begin
         istat_r <= '0;
         imask_r <= `RCU_IMASK_RST;
         irq_r <= 1'b0;
      end else begin
         istat_r <= istat_nxt;
         irq_r <= |(istat_nxt & imask_r);
         if (wr_imask) begin
            imask_r <= wdata_in[`RCU_IRQ_W-1:0];
         end
      end
   end

   // Wake-up follows the pending sub-second flag
   always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         wake_r <= 1'b0;
      end else begin
         wake_r <= ssal_nxt; //RQ10
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Read path

   // Direct read bypasses the synchronised copy; software must re-read
   wire [31:0] sec_view = rd_en_r ? sec_r : sec_sh_r; //RQ4 RQ5
   wire [`RCU_SSEC_W-1:0] ssec_view = rd_en_r ? ssec_r : ssec_sh_r; //RQ4
   // Control word; reserved bits and left-out enables read zero
   wire [31:0] ctrl_view = {16'h0, wr_en_r, rd_en_r, 3'h0, sqw_sel_r, //RQ17
                            sqw_en_r, ssal_r, todal_r, 1'b0, rdy_r,
                            busy, 2'h0, en_r};
   // Unmapped offsets read zero
   wire [31:0] rd_mux =
      sel_sec ? sec_view :
      sel_ssec ? {20'h0, ssec_view} :
      sel_toda ? {12'h0, toda_r} :
      sel_sseca ? sseca_r :
      sel_ctrl ? ctrl_view :
      sel_trim ? {24'h0, trim_r} :
      sel_istat ? {29'h0, istat_r} :
      sel_imask ? {29'h0, imask_r} : 32'h0;

   // Data stand for the one cycle after the strobe
   always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         rdata_r <= 32'h0;
      end else begin
         rdata_r <= rd_in ? rd_mux : 32'h0;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Square wave and outputs

   // Rates come off the untrimmed sub-second count and the prescaler; trim_r is not applied
   rcu_sqw_gen u_sqw (
      .sys_clk_in(sys_clk_in),
      .rst_n_in(rst_n_in),
      .en_in(sqw_en_r),
      .sel_in(sqw_sel_r),
      .hz1_in(ssec_r[`RCU_SSEC_W-1]),
      .hz512_in(ssec_r[2]),
      .khz4_in(presc_r[2]),
      .sqw_out(sqw_out)
   );

   assign rdata_out = rdata_r;
   assign wakeup_out = wake_r;
   assign irq_out = irq_r;
endmodule

// [logic/rcu_params.svh]
// Offsets, field positions, reset values and timing for the RTC control block.
// Assumes a byte-addressed register port with one 32-bit word per register.
`ifndef RCU_PARAMS_SVH
`define RCU_PARAMS_SVH
// Register offsets
`define RCU_OFF_SEC 8'h00
`define RCU_OFF_SSEC 8'h04
`define RCU_OFF_TODA 8'h08
`define RCU_OFF_SSECA 8'h0c
`define RCU_OFF_CTRL 8'h10
`define RCU_OFF_TRIM 8'h14
`define RCU_OFF_ISTAT 8'h20
`define RCU_OFF_IMASK 8'h24
// Control field positions
`define RCU_B_WREN 15
`define RCU_B_RDEN 14
`define RCU_B_SELHI 10
`define RCU_B_SELLO 9
`define RCU_B_SQWEN 8
`define RCU_B_SSAL 7
`define RCU_B_TODAL 6
`define RCU_B_RDY 4
`define RCU_B_BUSY 3
`define RCU_B_EN 0
// Field widths and reset values
`define RCU_SSEC_W 12
`define RCU_TODA_W 20
`define RCU_TRIM_W 8
`define RCU_IRQ_W 3
`define RCU_TRIM_RST 8'h00
`define RCU_IMASK_RST 3'h0
// Timing: clock rate, ready window, busy transfer length
`define RCU_CLK_MHZ 250
`define RCU_RDY_TIME_NS 120000
`define RCU_BUSY_CYC 8
`endif

// [logic/rcu_pkg.sv]
// Types shared by the RTC control block.
// Assumes rcu_params.svh is seen by the files that need constants.
package rcu_pkg;
   // Square-wave source selection, in field encoding order
   typedef enum logic [1:0] {
      RCU_SQW_1HZ,
      RCU_SQW_512HZ,
      RCU_SQW_4KHZ,
      RCU_SQW_RSVD
   } rcu_sqw_sel_t;
endpackage

// [logic/rcu_sqw_gen.sv]
// Square-wave output selector for the RTC control block.
// Assumes the sub-second count and the 4 kHz phase come from the parent.
module rcu_sqw_gen
   import rcu_pkg::*;
(
   // Clock and reset
   input wire logic sys_clk_in,
   input wire logic rst_n_in,
   // Controls
   input wire logic en_in,
   input wire logic [1:0] sel_in,
   // Frequency sources
   input wire logic hz1_in,
   input wire logic hz512_in,
   input wire logic khz4_in,
   // Pin
   output logic sqw_out
);
   rcu_sqw_sel_t sel;
   logic pick;

   // Decode the select field
   assign sel = rcu_sqw_sel_t'(sel_in);
   // Reserved code and disable both park the pin low
   assign pick = !en_in ? 1'b0 : //RQ8
                 (sel == RCU_SQW_1HZ) ? hz1_in : //RQ7
                 (sel == RCU_SQW_512HZ) ? hz512_in :
                 (sel == RCU_SQW_4KHZ) ? khz4_in : 1'b0;

   // Registered so the pin never glitches on a select change
   always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         sqw_out <= 1'b0;
      end else begin
         sqw_out <= pick;
      end
   end
endmodule

// [test/rcu_ctrl_checker.sv]
// Port-level assertions for the RTC control block, bound to rcu_ctrl.
// Assumes rcu_params.svh on the include path; sees only the block's ports.
`include "rcu_params.svh"
module rcu_ctrl_checker #(
   parameter int BUSY_CYC = `RCU_BUSY_CYC
) (
   // Clock and resets
   input wire logic sys_clk_in,
   input wire logic rst_n_in,
   input wire logic sys_reset_in,
   input wire logic soft_reset_in,
   input wire logic peripheral_reset_request_in,
   input wire logic alt_peripheral_reset_request_in,
   // Register port and pins
   input wire logic [7:0] addr_in,
   input wire logic wr_in,
   input wire logic rd_in,
   input wire logic [31:0] rdata_out,
   input wire logic sqw_out,
   input wire logic wakeup_out,
   input wire logic irq_out
);
   // Last cycle still inside the busy window under either edge reading
   localparam int BUSY_LAST = BUSY_CYC - 1;
   // Any warm reset source
   wire logic warm = sys_reset_in | soft_reset_in | peripheral_reset_request_in |
      alt_peripheral_reset_request_in;
   // Control register read request
   wire logic rd_ctrl = rd_in && (addr_in == `RCU_OFF_CTRL);
   default clocking cb @(posedge sys_clk_in); endclocking
   default disable iff (!rst_n_in);
   ////////////////////////////////////////////////////////////////////////////////
   rsv_read_zero_a: assert property ($past(rd_ctrl) |-> rdata_out[31:16] == 16'h0 &&
      rdata_out[13:11] == 3'h0) else $error("reserved control bits not zero");
   rdata_idle_a: assert property (!$past(rd_in) |-> rdata_out == 32'h0)
      else $error("read data without a read");
   wake_mirror_a: assert property ($past(rd_ctrl) |-> rdata_out[7] == $past(wakeup_out))
      else $error("wakeup differs from sub-second flag");
   wake_hold_a: assert property (warm && wakeup_out |=> wakeup_out)
      else $error("warm reset dropped wakeup");
   unlock_clear_a: assert property (warm ##1 rd_ctrl |=> rdata_out[15:14] == 2'h0 &&
      !rdata_out[0]) else $error("unlock survived warm reset");
   busy_set_a: assert property ((wr_in && addr_in == `RCU_OFF_SEC && !warm) ##[2:BUSY_LAST]
      rd_ctrl |=> rdata_out[`RCU_B_BUSY]) else $error("busy missing after counter write");
   irq_masked_a: assert property ($past(rd_in && addr_in == `RCU_OFF_IMASK) &&
      rdata_out[2:0] == 3'h0 |-> !irq_out) else $error("irq high with empty mask");
   sqw_off_a: assert property ($past(rd_ctrl) && (!rdata_out[8] || rdata_out[10:9] == 2'h3)
      |-> !sqw_out) else $error("square wave active while off");
   // Main scenarios reached
   cover property (rd_ctrl ##1 rdata_out[7]);
   cover property ($rose(irq_out));
   cover property (rd_ctrl ##1 rdata_out[`RCU_B_BUSY]);
endmodule

// [test/tb_rcu_ctrl.sv]
// Self-checking bench for the RTC control block; binds the port checker.
// Assumes rcu_pkg, rcu_sqw_gen and rcu_ctrl are compiled before it.
`include "rcu_params.svh"
module tb_rcu_ctrl;
   timeunit 1ns;
   timeprecision 1ps;
   localparam int RDY_T = 50; // Short ready window keeps the run brief
   localparam int BUSY_T = `RCU_BUSY_CYC;
   logic sys_clk_in = 1'b0;
   logic rst_n_in = 1'b0;
   logic [3:0] warm = 4'h0; // Warm reset sources, one bit each
   logic tick_run = 1'b0; // Timebase runs while set
   logic lf_tick = 1'b0;
   logic [7:0] addr = 8'h00;
   logic [31:0] wdata = 32'h0;
   logic wr = 1'b0;
   logic rd = 1'b0;
   logic [31:0] rdata;
   logic sqw;
   logic wake;
   logic irq;
   logic [31:0] lfsr = 32'hcebf8aae;
   logic [31:0] d;
   logic [31:0] d2;
   logic prev;
   int bad_count = 0;
   int cmp_count = 0;
   int cyc = 0;
   int tog;
   always #2 sys_clk_in = ~sys_clk_in;
   rcu_ctrl #(.RDY_CYC(RDY_T), .BUSY_CYC(BUSY_T)) DUT (
      .sys_clk_in(sys_clk_in), .rst_n_in(rst_n_in), .sys_reset_in(warm[0]),
      .soft_reset_in(warm[1]), .peripheral_reset_request_in(warm[2]),
      .alt_peripheral_reset_request_in(warm[3]), .lf_tick_in(lf_tick), .addr_in(addr),
      .wdata_in(wdata), .wr_in(wr), .rd_in(rd), .rdata_out(rdata), .sqw_out(sqw),
      .wakeup_out(wake), .irq_out(irq));
   ////////////////////////////////////////////////////////////////////////////////
   // Tick every other cycle, so it stays a true one-cycle pulse
   always @(posedge sys_clk_in) begin
      lf_tick <= tick_run && !lf_tick;
   end
   // Hang guard: the sequence needs well under 20000 cycles
   always @(posedge sys_clk_in) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         bad_count++;
         end_of_test();
      end
   end
   function automatic logic [31:0] lfsr_next(logic [31:0] x);
      return (x >> 1) ^ (x[0] ? 32'h80200003 : 32'h0);
   endfunction
   // Sqw toggles in 1024 cycles; a sub-second step is 16 cycles
   function automatic int exp_tog(int sel);
      case (sel)
         1: return 1024 / 64; // Sub-second bit 2
         2: return 1024 / 8; // Prescaler bit 2
         default: return 0; // Slow, reserved or disabled
      endcase
   endfunction
   task automatic wr_reg(logic [7:0] a, logic [31:0] v);
      @(posedge sys_clk_in);
      wr <= 1'b1; addr <= a; wdata <= v;
      @(posedge sys_clk_in);
      wr <= 1'b0;
   endtask
   // Data stand only in the cycle after the strobe
   task automatic rd_reg(logic [7:0] a, output logic [31:0] v);
      @(posedge sys_clk_in);
      rd <= 1'b1; addr <= a;
      @(posedge sys_clk_in);
      rd <= 1'b0;
      #1 v = rdata;
   endtask
   task automatic idle(int n);
      repeat (n) @(posedge sys_clk_in);
   endtask
   task automatic chk(logic [31:0] got, logic [31:0] exp);
      cmp_count++;
      if (got !== exp) begin
         bad_count++;
         $display("BAD t=%0t got %h expected %h", $time, got, exp);
      end
   endtask
   // Counts may be off by one edge of phase
   task automatic chk_cnt(int got, int exp);
      cmp_count++;
      if (got > exp + 1 || got < exp - 1) begin
         bad_count++;
         $display("BAD t=%0t count %0d expected %0d", $time, got, exp);
      end
   endtask
   task automatic end_of_test();
      $display("comparisons %0d mismatches %0d", cmp_count, bad_count);
      if (bad_count == 0 && cmp_count > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask
   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      idle(16);
      rst_n_in <= 1'b1;
      // Power-on values, unmapped place, empty mask
      rd_reg(`RCU_OFF_CTRL, d); chk(d, 32'h0);
      rd_reg(8'h30, d); chk(d, 32'h0);
      rd_reg(`RCU_OFF_IMASK, d); chk(d, 32'h0);
      $display("test reset done");
      // Locked trim and run enable, then unlocked with busy
      lfsr = lfsr_next(lfsr);
      wr_reg(`RCU_OFF_TRIM, {24'h0, lfsr[7:0]});
      rd_reg(`RCU_OFF_TRIM, d); chk(d, 32'h0);
      wr_reg(`RCU_OFF_CTRL, 32'h1);
      rd_reg(`RCU_OFF_CTRL, d); chk(d, 32'h0);
      wr_reg(`RCU_OFF_CTRL, 32'h8000);
      wr_reg(`RCU_OFF_TRIM, {24'h0, lfsr[7:0]});
      rd_reg(`RCU_OFF_CTRL, d); chk(d & 32'h8, 32'h8);
      wr_reg(`RCU_OFF_CTRL, 32'h8100); // Dropped while busy
      idle(BUSY_T + 2);
      rd_reg(`RCU_OFF_CTRL, d); chk(d, 32'h8000);
      rd_reg(`RCU_OFF_TRIM, d); chk(d, {24'h0, lfsr[7:0]});
      $display("test unlock done");
      // Random control words; run enable kept off so nothing counts
      for (int i = 0; i < 8; i++) begin
         lfsr = lfsr_next(lfsr);
         wr_reg(`RCU_OFF_CTRL, lfsr & 32'hffffff3e);
         rd_reg(`RCU_OFF_CTRL, d); chk(d, lfsr & 32'h0000c700);
      end
      $display("test random control done");
      // Every select code, then output disabled
      wr_reg(`RCU_OFF_CTRL, 32'h8000);
      tick_run <= 1'b1;
      for (int i = 0; i < 5; i++) begin
         wr_reg(`RCU_OFF_CTRL, (i < 4) ? (32'hc101 | (i << 9)) : 32'hc401);
         prev = sqw;
         tog = 0;
         repeat (1024) begin
            @(negedge sys_clk_in);
            if (sqw !== prev) tog++;
            prev = sqw;
         end
         chk_cnt(tog, exp_tog(i));
      end
      // Live reads two steps apart
      rd_reg(`RCU_OFF_SSEC, d);
      idle(30);
      rd_reg(`RCU_OFF_SSEC, d2); chk((d2 - d) & 32'hfff, 32'h2);
      // Direct mode: re-read until two reads agree; all ones never reads back
      d = 32'hffffffff;
      d2 = 32'h0;
      for (int n = 0; n < 8 && d !== d2; n++) begin
         d2 = d;
         rd_reg(`RCU_OFF_SSEC, d);
      end
      chk(d, d2);
      $display("test square wave done");
      // Counter load, both alarms, status and ready window
      tick_run <= 1'b0;
      wr_reg(`RCU_OFF_CTRL, 32'h8000);
      wr_reg(`RCU_OFF_SEC, 32'h0);
      rd_reg(`RCU_OFF_CTRL, d); chk(d & 32'h8, 32'h8);
      idle(BUSY_T + 2);
      wr_reg(`RCU_OFF_SSEC, 32'hffe);
      idle(BUSY_T + 2);
      wr_reg(`RCU_OFF_TODA, 32'h1);
      wr_reg(`RCU_OFF_SSECA, 32'hfffffffd);
      wr_reg(`RCU_OFF_IMASK, 32'h3);
      wr_reg(`RCU_OFF_CTRL, 32'h8001);
      tick_run <= 1'b1;
      idle(70);
      tick_run <= 1'b0;
      rd_reg(`RCU_OFF_CTRL, d); chk(d & 32'hc0d1, 32'h80d1);
      chk({30'h0, wake, irq}, 32'h3);
      rd_reg(`RCU_OFF_ISTAT, d); chk(d & 32'h3, 32'h3);
      chk({31'h0, irq}, 32'h0);
      // Synchronised view holds the seconds value after the wrap
      rd_reg(`RCU_OFF_SEC, d); chk(d, 32'h1);
      idle(RDY_T + 10);
      rd_reg(`RCU_OFF_CTRL, d); chk(d & 32'h10, 32'h0);
      $display("test alarms done");
      // Each warm source clears unlock but keeps power-on fields
      for (int i = 0; i < 4; i++) begin
         wr_reg(`RCU_OFF_CTRL, 32'hc5c0);
         @(posedge sys_clk_in);
         warm <= 4'(1 << i);
         // One-cycle pulse, read strobe in the very next cycle
         fork
            rd_reg(`RCU_OFF_CTRL, d);
            @(posedge sys_clk_in) warm <= 4'h0;
         join
         chk(d & 32'hc7c1, 32'h05c0);
         chk({31'h0, wake}, 32'h1);
      end
      // Zero clears a flag, one leaves it
      wr_reg(`RCU_OFF_CTRL, 32'h40);
      rd_reg(`RCU_OFF_CTRL, d); chk(d & 32'hc0, 32'h40);
      chk({31'h0, wake}, 32'h0);
      $display("test warm reset done");
      end_of_test();
   end
endmodule
bind rcu_ctrl rcu_ctrl_checker #(.BUSY_CYC(BUSY_CYC)) chk_i (
   .sys_clk_in(sys_clk_in), .rst_n_in(rst_n_in), .sys_reset_in(sys_reset_in),
   .soft_reset_in(soft_reset_in), .peripheral_reset_request_in(peripheral_reset_request_in),
   .alt_peripheral_reset_request_in(alt_peripheral_reset_request_in), .addr_in(addr_in),
   .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out), .sqw_out(sqw_out),
   .wakeup_out(wakeup_out), .irq_out(irq_out));
